// ===== verilog/hmcg_pkg.sv
// Package: types and constants for the pause-mode clock gating block
package hmcg_pkg;

    // ************************************************************
    // Clock sources and selections
    // ************************************************************
    // CPU clock source in use when the pause instruction runs
    typedef enum logic [1:0] {
        HMCG_SRC_XTAL,
        HMCG_SRC_OSC,
        HMCG_SRC_SUB
    } hmcg_src_e;

    // Count source chosen for the watch timer
    typedef enum logic [1:0] {
        HMCG_WSEL_XTAL,
        HMCG_WSEL_SUB,
        HMCG_WSEL_OTHER
    } hmcg_wsel_e;

    // Count clock choices of the peripheral timers
    typedef struct packed {
        logic timer_a_on_pin;       // Timer A counts timer_a_count_pin
        logic timer_b_on_pin;       // Timer B counts timer_b_count_pin
        logic itv0_on_timer_a_out;  // Interval timer 0 clocked by timer_a_output
        logic timer_a_running;      // Timer A is counting
        logic itv1_on_osc_div;      // Interval timer 1 on internal osc divided
        logic sub_used;             // Subsystem clock is in use
        hmcg_wsel_e watch_sel;      // Watch timer count source
    } hmcg_sel_s;

    // Per-peripheral count clock enables
    typedef struct packed {
        logic tmr16;
        logic timer_a;
        logic timer_b;
        logic itv0;
        logic itv1;
        logic watch;
        logic wdt;
    } hmcg_gate_s;

    // ************************************************************
    // Reset values and figures
    // ************************************************************
    localparam int HMCG_PORT_W = 8;
    localparam logic [HMCG_PORT_W-1:0] HMCG_PORT_RST = 8'h00;
    localparam hmcg_gate_s HMCG_GATE_RST = 7'h7F;
    localparam logic HMCG_OPT_RST = 1'b0;
    localparam int HMCG_OSC_DIV_LOG2 = 7;

endpackage : hmcg_pkg

// ===== verilog/hmcg_halt_ctrl.sv
// Pause-mode controller: CPU clock gate, port hold and peripheral clock enables
`timescale 1ns/1ps

// Summary of operation
// [R01] Only the pause instruction enters pause
// [R02] Entry accepted from any CPU clock source
// [R03] CPU clock gated off throughout pause
// [R04] Port latches hold pre-entry values
// [R05] 16-bit timer runs only on crystal entry
// [R06] 8-bit counters: osc entry needs pin source
// [R07] Interval timer 0: osc entry needs timer A
// [R08] Interval timer 1: osc entry needs divider
// [R09] Watch timer depends on subsystem clock use
// [R10] Watchdog halts when osc is stoppable
// [R11] Osc stopped only if stoppable and stopped
// [R12] Crystal entry, no subclock: watch needs crystal
// [R13] Osc entry with subclock: watch needs subclock
// [R14] Stoppable option is a one-time strap
// [R15] Interrupt or reset releases pause
// [R16] Operable peripherals keep their count clocks
module hmcg_halt_ctrl #(
    parameter int PORT_W = hmcg_pkg::HMCG_PORT_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic halt_exec,
    input wire hmcg_pkg::hmcg_src_e cpu_src,
    input wire logic int_req,
    input wire logic osc_stoppable_pin,
    input wire logic osc_sw_stopped,
    input wire hmcg_pkg::hmcg_sel_s sel,
    input wire logic port_wr,
    input wire logic [PORT_W-1:0] port_wdata,
    output logic cpu_clk_en,
    output logic halted,
    output hmcg_pkg::hmcg_src_e entry_src,
    output logic [PORT_W-1:0] port_out,
    output hmcg_pkg::hmcg_gate_s gate
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic {HMCG_ST_RUN, HMCG_ST_HALT} hmcg_state_e;

    hmcg_state_e state_ff;
    hmcg_state_e nxt_state;
    hmcg_pkg::hmcg_src_e src_ff;
    hmcg_pkg::hmcg_src_e nxt_src;
    logic [PORT_W-1:0] port_ff;
    logic [PORT_W-1:0] nxt_port;
    hmcg_pkg::hmcg_gate_s gate_ff;
    hmcg_pkg::hmcg_gate_s nxt_gate;
    logic opt_meta_ff;
    logic opt_sync_ff;
    logic opt_ff;
    logic nxt_opt;
    logic opt_cap_ff;
    logic nxt_opt_cap;
    logic [1:0] fill_ff;
    logic [1:0] nxt_fill;
    logic osc_stopped;

    // ************************************************************
    // Factory option strap capture
    // ************************************************************
    // Strap sampled once the synchroniser has filled, frozen afterwards
    always_comb begin
        nxt_opt = opt_ff;
        nxt_opt_cap = opt_cap_ff;
        nxt_fill = {fill_ff[0], 1'b1}; // Two edges until sync output is valid
        if (fill_ff[1] && !opt_cap_ff) begin
            nxt_opt = opt_sync_ff; // [R14]
            nxt_opt_cap = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            opt_meta_ff <= hmcg_pkg::HMCG_OPT_RST;
            opt_sync_ff <= hmcg_pkg::HMCG_OPT_RST;
            opt_ff <= hmcg_pkg::HMCG_OPT_RST;
            opt_cap_ff <= 1'b0;
            fill_ff <= 2'h0;
        end else if (clk_en) begin
            opt_meta_ff <= osc_stoppable_pin;
            opt_sync_ff <= opt_meta_ff;
            opt_ff <= nxt_opt;
            opt_cap_ff <= nxt_opt_cap;
            fill_ff <= nxt_fill;
        end
    end

    // Oscillator counts as stopped only when allowed and stopped
    assign osc_stopped = opt_ff && osc_sw_stopped; // [R11]

    // ************************************************************
    // Pause state machine and port latch
    // ************************************************************
    // Enter on the instruction only, leave on interrupt
    always_comb begin
        nxt_state = state_ff;
        nxt_src = src_ff;
        nxt_port = port_ff;
        case (state_ff)
            HMCG_ST_RUN: begin
                if (port_wr) begin
                    nxt_port = port_wdata;
                end
                if (halt_exec) begin
                    nxt_state = HMCG_ST_HALT; // [R01]
                    nxt_src = cpu_src; // [R02]
                end
            end
            HMCG_ST_HALT: begin
                if (int_req) begin
                    nxt_state = HMCG_ST_RUN; // [R15]
                end
            end
            default: begin
                nxt_state = HMCG_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= HMCG_ST_RUN; // [R15]
            src_ff <= hmcg_pkg::HMCG_SRC_XTAL;
            port_ff <= PORT_W'(hmcg_pkg::HMCG_PORT_RST);
        end else if (clk_en) begin
            state_ff <= nxt_state;
            src_ff <= nxt_src;
            port_ff <= nxt_port; // [R04]
        end
    end

    // ************************************************************
    // Peripheral clock enables
    // ************************************************************
    // Keep guaranteed peripherals clocked, gate the rest in pause
    always_comb begin
        nxt_gate = hmcg_pkg::HMCG_GATE_RST;
        nxt_gate.wdt = 1'b1;
        if (nxt_state == HMCG_ST_HALT) begin
            nxt_gate.wdt = !opt_ff; // [R10]
            if (nxt_src == hmcg_pkg::HMCG_SRC_XTAL) begin
                nxt_gate.tmr16 = 1'b1; // [R05]
                nxt_gate.timer_a = 1'b1; // [R06]
                nxt_gate.timer_b = 1'b1; // [R06]
                nxt_gate.itv0 = 1'b1; // [R07]
                nxt_gate.itv1 = 1'b1; // [R08]
                nxt_gate.watch = sel.sub_used ||
                    (sel.watch_sel == hmcg_pkg::HMCG_WSEL_XTAL); // [R09] [R12]
            end else begin
                nxt_gate.tmr16 = 1'b0; // [R05]
                nxt_gate.timer_a = sel.timer_a_on_pin; // [R06]
                nxt_gate.timer_b = sel.timer_b_on_pin; // [R06]
                nxt_gate.itv0 = sel.itv0_on_timer_a_out && sel.timer_a_running; // [R07]
                nxt_gate.itv1 = sel.itv1_on_osc_div && !osc_stopped; // [R08]
                nxt_gate.watch = sel.sub_used &&
                    (sel.watch_sel == hmcg_pkg::HMCG_WSEL_SUB); // [R09] [R13]
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_ff <= hmcg_pkg::HMCG_GATE_RST;
        end else if (clk_en) begin
            gate_ff <= nxt_gate; // [R16]
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // CPU clock runs only outside pause
    assign cpu_clk_en = (state_ff == HMCG_ST_RUN); // [R03]
    assign halted = (state_ff == HMCG_ST_HALT);
    assign entry_src = src_ff;
    assign port_out = port_ff;
    assign gate = gate_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Entry only through the pause instruction
    entry_cause_a: assert property ( // [R01]
        @(posedge mclk) disable iff (!rst_n)
        $rose(halted) |-> $past(halt_exec) && $past(clk_en))
        else $error("Pause entered without the instruction");

    // Instruction in run with clk_en high always enters pause next cycle
    entry_any_src_a: assert property ( // [R02]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && !halted && halt_exec) |=> halted && entry_src == $past(cpu_src))
        else $error("Pause entry refused or source lost");

    // CPU clock off exactly while paused
    cpu_gate_a: assert property ( // [R03]
        @(posedge mclk) disable iff (!rst_n)
        cpu_clk_en != halted)
        else $error("CPU clock enable disagrees with pause");

    // Port latch frozen during pause
    port_hold_a: assert property ( // [R04]
        @(posedge mclk) disable iff (!rst_n)
        halted && $past(halted) |-> $stable(port_out))
        else $error("Port latch changed in pause");

    // 16-bit timer only kept on crystal entry
    tmr16_gate_a: assert property ( // [R05]
        @(posedge mclk) disable iff (!rst_n)
        halted && $stable(halted) && $stable(entry_src) && $past(clk_en)
        |-> gate.tmr16 == (entry_src == hmcg_pkg::HMCG_SRC_XTAL))
        else $error("16-bit timer gate wrong in pause");

    // Timer A on osc entry follows pin selection
    timer_a_gate_a: assert property ( // [R06]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && halted && int_req == 1'b0 && entry_src == hmcg_pkg::HMCG_SRC_OSC)
        |=> gate.timer_a == $past(sel.timer_a_on_pin))
        else $error("Timer A gate wrong on osc entry");

    // Interval timer 0 needs running timer A on osc entry
    itv0_gate_a: assert property ( // [R07]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && halted && !int_req && entry_src == hmcg_pkg::HMCG_SRC_OSC)
        |=> gate.itv0 == ($past(sel.itv0_on_timer_a_out) && $past(sel.timer_a_running)))
        else $error("Interval timer 0 gate wrong");

    // Interval timer 1 needs divided osc still running
    itv1_gate_a: assert property ( // [R08]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && halted && !int_req && entry_src != hmcg_pkg::HMCG_SRC_XTAL)
        |=> gate.itv1 == ($past(sel.itv1_on_osc_div) && !$past(osc_stopped)))
        else $error("Interval timer 1 gate wrong");

    // Watchdog stops in pause when osc is stoppable
    wdt_gate_a: assert property ( // [R10]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && halted && !int_req) |=> gate.wdt == !opt_ff)
        else $error("Watchdog gate wrong in pause");

    // Watch timer on osc entry needs subsystem source
    watch_gate_a: assert property ( // [R13]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && halted && !int_req && entry_src != hmcg_pkg::HMCG_SRC_XTAL)
        |=> gate.watch == ($past(sel.sub_used) && $past(sel.watch_sel) == hmcg_pkg::HMCG_WSEL_SUB))
        else $error("Watch timer gate wrong");

    // Interrupt releases pause within one cycle
    wake_a: assert property ( // [R15]
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && halted && int_req) |=> cpu_clk_en ##0 gate == hmcg_pkg::HMCG_GATE_RST)
        else $error("Interrupt did not release pause");

    // Strap frozen once captured
    opt_hold_a: assert property ( // [R14]
        @(posedge mclk) disable iff (!rst_n)
        opt_cap_ff && $past(opt_cap_ff) |-> $stable(opt_ff))
        else $error("Stoppable option changed at run time");

endmodule : hmcg_halt_ctrl

// ===== bench/hmcg_cpu_model.sv
// CPU core model: issues the pause instruction and wake-up interrupts
`timescale 1ns/1ps
module hmcg_cpu_model (
    input wire logic mclk,
    output logic halt_exec,
    output logic int_req
);
    // ************************************************************
    // Instruction and interrupt drivers
    // ************************************************************
    // Idle levels at time zero
    initial begin
        halt_exec = 1'b0;
        int_req = 1'b0;
    end

    // One-cycle pause instruction pulse, the only way
    task automatic pause();
        @(posedge mclk);
        #1 halt_exec = 1'b1;
        @(posedge mclk);
        #1 halt_exec = 1'b0;
    endtask : pause

    // One-cycle enabled interrupt request releases pause
    task automatic wake();
        @(posedge mclk);
        #1 int_req = 1'b1;
        @(posedge mclk);
        #1 int_req = 1'b0;
    endtask : wake
endmodule : hmcg_cpu_model

// ===== bench/tb_hmcg_halt_ctrl.sv
// Testbench for the pause-mode clock gating controller
`timescale 1ns/1ps
module tb_hmcg_halt_ctrl;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, strap = 1'b0, sw_stop = 1'b0, port_wr = 1'b0;
    logic halt_exec, int_req, cpu_clk_en, halted;
    logic [7:0] port_wdata = 8'h00, port_out;
    hmcg_pkg::hmcg_src_e cpu_src = hmcg_pkg::HMCG_SRC_XTAL, entry_src;
    hmcg_pkg::hmcg_sel_s sel = '0;
    hmcg_pkg::hmcg_gate_s gate;
    int failures = 0, n_compared = 0;
    logic [7:0] tbl [4] = '{8'hFD, 8'h00, 8'h58, 8'hE1};

    always #20 mclk = ~mclk;

    hmcg_cpu_model cpu (.mclk(mclk), .halt_exec(halt_exec), .int_req(int_req));

    hmcg_halt_ctrl #(.PORT_W(8)) DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .halt_exec(halt_exec),
        .cpu_src(cpu_src), .int_req(int_req), .osc_stoppable_pin(strap), .osc_sw_stopped(sw_stop),
        .sel(sel), .port_wr(port_wr), .port_wdata(port_wdata), .cpu_clk_en(cpu_clk_en),
        .halted(halted), .entry_src(entry_src), .port_out(port_out), .gate(gate));

    // ************************************************************
    // Helpers
    // ************************************************************
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Step to just after the n-th edge from now
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // Reset for four cycles, then let the strap be captured
    task automatic do_reset();
        rst_n = 1'b0;
        step(4);
        rst_n = 1'b1;
        step(3);
    endtask : do_reset

    // Expected peripheral clock enables during pause
    function automatic hmcg_pkg::hmcg_gate_s exp_gate(input hmcg_pkg::hmcg_src_e src, input hmcg_pkg::hmcg_sel_s s);
        hmcg_pkg::hmcg_gate_s g;
        g.wdt = !strap;
        if (src == hmcg_pkg::HMCG_SRC_XTAL) begin
            {g.tmr16, g.timer_a, g.timer_b, g.itv0, g.itv1} = 5'h1F;
            g.watch = s.sub_used | (s.watch_sel == hmcg_pkg::HMCG_WSEL_XTAL);
        end else begin
            g.tmr16 = 1'b0;
            g.timer_a = s.timer_a_on_pin;
            g.timer_b = s.timer_b_on_pin;
            g.itv0 = s.itv0_on_timer_a_out & s.timer_a_running;
            g.itv1 = s.itv1_on_osc_div & !(strap & sw_stop);
            g.watch = s.sub_used & (s.watch_sel == hmcg_pkg::HMCG_WSEL_SUB);
        end
        return g;
    endfunction : exp_gate

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Crystal entry, port hold, refused requests, exit and re-entry
    task automatic t_xtal();
        port_wr = 1'b1;
        port_wdata = 8'hA5;
        step(1);
        port_wr = 1'b0;
        clk_en = 1'b0;
        cpu.pause();
        chk(16'(halted), 16'h0000);
        clk_en = 1'b1;
        sel = 8'h02;
        cpu.pause();
        chk(16'({halted, cpu_clk_en}), 16'h0002);
        chk(16'(gate), 16'(exp_gate(hmcg_pkg::HMCG_SRC_XTAL, sel)));
        port_wr = 1'b1;
        port_wdata = 8'h5A;
        cpu.pause();
        port_wr = 1'b0;
        chk(16'({halted, port_out}), 16'h01A5);
        cpu.wake();
        chk(16'({halted, cpu_clk_en, gate}), 16'h00FF);
        cpu.pause();
        chk(16'(halted), 16'h0001);
        sel = 8'h06;
        step(2);
        chk(16'(gate), 16'(exp_gate(hmcg_pkg::HMCG_SRC_XTAL, sel)));
        cpu.wake();
    endtask : t_xtal

    // Ring-oscillator and subsystem entries over a table of selections
    task automatic t_osc();
        for (int k = 0; k < 8; k++) begin
            cpu_src = (k < 4) ? hmcg_pkg::HMCG_SRC_OSC : hmcg_pkg::HMCG_SRC_SUB;
            sel = tbl[k % 4];
            cpu.pause();
            chk(16'(entry_src), 16'(cpu_src));
            chk(16'(gate), 16'(exp_gate(cpu_src, sel)));
            sel = tbl[(k + 1) % 4];
            step(2);
            chk(16'(gate), 16'(exp_gate(cpu_src, sel)));
            cpu.wake();
        end
    endtask : t_osc

    // Stoppable oscillator strap, stopped by software, strap frozen
    task automatic t_strap();
        strap = 1'b1;
        sw_stop = 1'b1;
        do_reset();
        cpu_src = hmcg_pkg::HMCG_SRC_OSC;
        sel = 8'hFD;
        cpu.pause();
        chk(16'(gate), 16'(exp_gate(cpu_src, sel)));
        strap = 1'b0;
        step(6);
        strap = 1'b1;
        chk(16'(gate), 16'(exp_gate(cpu_src, sel)));
        cpu.wake();
    endtask : t_strap

    // ************************************************************
    // Sequence, watchdog and verdict
    // ************************************************************
    // Print counts and the verdict, then stop
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        do_reset();
        chk(16'({cpu_clk_en, halted, entry_src, port_out}), 16'h0800);
        chk(16'(gate), 16'(hmcg_pkg::HMCG_GATE_RST));
        t_xtal();
        t_osc();
        t_strap();
        results();
    end

    // Hang guard
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule : tb_hmcg_halt_ctrl
